// ===== design/freq_limit_pkg.sv
// Shared constants and types for the output frequency limiter
package freq_limit_pkg;

  // Frequencies are carried in units of 0.1 Hz
  typedef logic [15:0] freq_t;
  typedef logic [3:0]  addr_t;

  localparam int    FREQ_W        = 16;
  localparam int    NUM_BANDS     = 3;
  localparam int    NUM_EDGES     = 6;

  // Frequency landmarks
  localparam freq_t FREQ_ZERO     = 16'h0000;  // 0 Hz
  localparam freq_t FREQ_50HZ     = 16'h01f4;  // 50 Hz, analog gain default ceiling
  localparam freq_t FREQ_120HZ    = 16'h04b0;  // 120 Hz
  localparam freq_t FREQ_400HZ    = 16'h0fa0;  // 400 Hz
  localparam freq_t SKIP_DISABLED = 16'h270f;  // Setting code 9999

  // Reset values
  localparam freq_t MAX_FREQ_RST  = FREQ_120HZ;
  localparam freq_t LOWER_RST     = FREQ_ZERO;
  localparam freq_t JOG_RST       = 16'h0032;  // 5 Hz
  localparam freq_t START_RST     = 16'h0005;  // 0.5 Hz
  localparam freq_t UGRS_RST      = 16'h0000;
  localparam freq_t SKIP_RST      = SKIP_DISABLED;

  // Register offsets
  localparam addr_t OFF_UPPER     = 4'h0;
  localparam addr_t OFF_LOWER     = 4'h1;
  localparam addr_t OFF_CEILING   = 4'h2;
  localparam addr_t OFF_JOG       = 4'h3;
  localparam addr_t OFF_START     = 4'h4;
  localparam addr_t OFF_UGRS      = 4'h5;
  localparam addr_t OFF_SKIP_BASE = 4'h6;  // Six edges at 0x6..0xb
  localparam addr_t OFF_STATUS    = 4'hc;
  localparam addr_t OFF_TARGET    = 4'hd;
  localparam addr_t OFF_RUNNING   = 4'he;

  // Status field positions
  localparam int    ST_UPPER      = 0;
  localparam int    ST_LOWER      = 1;
  localparam int    ST_SKIP       = 2;
  localparam int    ST_REJECT     = 3;
  localparam int    ST_JOG_PREC   = 4;

endpackage

// ===== design/skip_band.sv
// One skip band: detects a command inside the band and gives its jump point
`timescale 1ns/1ps
module skip_band
  import freq_limit_pkg::*;
(
  input  wire freq_t freq_in,
  input  wire freq_t edge_a,
  input  wire freq_t edge_b,
  output logic       hit,
  output freq_t      jump_point
);

  logic  enabled;
  freq_t band_lo;
  freq_t band_hi;

  // Band bounds in either order; either edge disabled kills the band
  assign enabled    = (edge_a != SKIP_DISABLED) && (edge_b != SKIP_DISABLED);
  assign band_lo    = (edge_a <= edge_b) ? edge_a : edge_b;
  assign band_hi    = (edge_a <= edge_b) ? edge_b : edge_a;
  assign hit        = enabled && (freq_in >= band_lo) && (freq_in <= band_hi);
  // Edge A is always the hold point, whether it is the low or high edge
  assign jump_point = edge_a;

endmodule // skip_band

// ===== design/freq_clamp.sv
// Lower and upper clamp with jog precedence over the lower limit
`timescale 1ns/1ps
module freq_clamp
  import freq_limit_pkg::*;
(
  input  wire freq_t  freq_in,
  input  wire freq_t  lower_limit,
  input  wire freq_t  upper_limit,
  input  wire logic   jog_mode,
  output freq_t       freq_out,
  output logic        at_upper,
  output logic        at_lower,
  output logic        jog_prec
);

  // Jog at or below the lower limit runs unraised
  assign jog_prec = jog_mode && (freq_in <= lower_limit);
  assign at_upper = freq_in > upper_limit;
  assign at_lower = !at_upper && !jog_prec && (freq_in < lower_limit);

  // Upper clamp first, then lower clamp unless jog takes precedence
  always_comb begin
    if (at_upper) begin
      freq_out = upper_limit;
    end else if (at_lower) begin
      freq_out = lower_limit;
    end else begin
      freq_out = freq_in;
    end
  end

endmodule // freq_clamp

// ===== design/output_frequency_limiter.sv
// Output frequency limiter: limits, skip bands, jog precedence and settings
//
// Contract
// (RULE_01) Command above the upper limit outputs the upper limit; range 0-120 Hz, reset 120.
// (RULE_02) Separate high-speed ceiling, 120-400 Hz, is the upper limit above 120 Hz.
// (RULE_03) Writing upper limit or high-speed ceiling copies the value into the other.
// (RULE_04) Set frequency below lower limit holds output at lower limit; 0-120 Hz, reset 0.
// (RULE_05) In jog, a jog setting at or below the lower limit is used unraised.
// (RULE_06) Start alone, lower limit above starting frequency, runs output to the lower limit.
// (RULE_07) Analog users must raise analog gain to exceed 50 Hz; limits alone do not.
// (RULE_08) Three skip bands, edges 0-400 Hz; code 9999 (reset value) disables an edge.
// (RULE_09) Command inside a skip band runs steadily at that band's A edge.
// (RULE_10) A low edge holds the low edge; A high edge holds the high edge.
// (RULE_11) Ramps pass through skip bands; avoidance applies only to the steady target.
// (RULE_12) Ceiling and skip edges are writable only when user group select is 0.
// (RULE_13) Skip mapping is applied first, then the limit clamps.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module output_frequency_limiter
  import freq_limit_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset_n,
  input  wire logic   clk_en,
  input  wire addr_t  addr,
  input  wire freq_t  wr_data,
  input  wire logic   wr_en,
  input  wire logic   rd_en,
  output freq_t       rd_data,
  input  wire freq_t  freq_cmd,
  input  wire logic   start,
  input  wire logic   jog,
  input  wire logic   ramp_active,
  input  wire freq_t  ramp_freq,
  output freq_t       target_freq,
  output freq_t       running_freq,
  output logic        upper_clamped,
  output logic        lower_clamped,
  output logic        skip_engaged
);

  // Settings
  freq_t max_freq;
  freq_t lower_freq_limit;
  freq_t jog_freq_setting;
  freq_t starting_freq_setting;
  freq_t user_group_read_select;
  freq_t skip_band_edges [NUM_EDGES];

  // Status
  logic  write_rejected;
  logic  jog_prec_seen;

  // Write decode
  logic  sel_upper;
  logic  sel_lower;
  logic  sel_ceiling;
  logic  sel_jog;
  logic  sel_start;
  logic  sel_ugrs;
  logic  sel_status;
  logic  sel_skip;
  logic  group_open;
  logic  ok_upper;
  logic  ok_lower;
  logic  ok_ceiling;
  logic  ok_jog;
  logic  ok_start;
  logic  ok_skip;
  logic  mapped_setting;
  logic  accepted;
  logic  in_skip_range;
  addr_t skip_index;

  // Datapath
  freq_t source_freq;
  freq_t skipped_freq;
  logic  any_hit;
  logic  band_hit   [NUM_BANDS];
  freq_t band_point [NUM_BANDS];
  freq_t limited_target;
  freq_t limited_running;
  logic  tgt_upper;
  logic  tgt_lower;
  logic  tgt_jog_prec;
  logic  run_jog_prec;
  logic  start_only;
  freq_t next_target;
  freq_t next_rd_data;

  // Address decode for every setting; range decode for all but user group select
  assign group_open  = (user_group_read_select == FREQ_ZERO);
  assign sel_upper   = wr_en && (addr == OFF_UPPER);
  assign sel_lower   = wr_en && (addr == OFF_LOWER);
  assign sel_ceiling = wr_en && (addr == OFF_CEILING);
  assign sel_jog     = wr_en && (addr == OFF_JOG);
  assign sel_start   = wr_en && (addr == OFF_START);
  assign sel_ugrs    = wr_en && (addr == OFF_UGRS);
  assign sel_status  = wr_en && (addr == OFF_STATUS);
  assign sel_skip    = wr_en && in_skip_range;

  // Edge window shared by the write and the read decode
  assign in_skip_range = (addr >= OFF_SKIP_BASE) && (addr < 4'(OFF_SKIP_BASE + NUM_EDGES));
  assign skip_index    = addr - OFF_SKIP_BASE;

  // (RULE_01) Upper limit range
  assign ok_upper    = sel_upper && (wr_data <= FREQ_120HZ);
  // (RULE_04) Lower limit range
  assign ok_lower    = sel_lower && (wr_data <= FREQ_120HZ);
  // (RULE_02) Ceiling range, (RULE_12) group lock
  assign ok_ceiling  = sel_ceiling && group_open
                     && (wr_data >= FREQ_120HZ) && (wr_data <= FREQ_400HZ);
  assign ok_jog      = sel_jog && (wr_data <= FREQ_400HZ);
  assign ok_start    = sel_start && (wr_data <= FREQ_400HZ);
  // (RULE_08) Edge range or disable code, (RULE_12) group lock
  assign ok_skip     = sel_skip && group_open
                     && ((wr_data <= FREQ_400HZ) || (wr_data == SKIP_DISABLED));

  assign mapped_setting = sel_upper || sel_lower || sel_ceiling || sel_jog
                        || sel_start || sel_skip;
  assign accepted       = ok_upper || ok_lower || ok_ceiling || ok_jog
                        || ok_start || ok_skip || sel_ugrs;

  // (RULE_03) One shared store for upper limit and ceiling
  // Two registers could drift apart on a refused write; one cannot
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      max_freq <= MAX_FREQ_RST;
    end else if (clk_en && (ok_upper || ok_ceiling)) begin
      max_freq <= wr_data;
    end
  end

  // Lower limit setting
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lower_freq_limit <= LOWER_RST;
    end else if (clk_en && ok_lower) begin
      lower_freq_limit <= wr_data;
    end
  end

  // Jog frequency setting
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      jog_freq_setting <= JOG_RST;
    end else if (clk_en && ok_jog) begin
      jog_freq_setting <= wr_data;
    end
  end

  // Starting frequency setting
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      starting_freq_setting <= START_RST;
    end else if (clk_en && ok_start) begin
      starting_freq_setting <= wr_data;
    end
  end

  // User group read selection, always writable
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      user_group_read_select <= UGRS_RST;
    end else if (clk_en && sel_ugrs) begin
      user_group_read_select <= wr_data;
    end
  end

  // Skip band edges, one register per edge
  // Only in-range values or the disable code reach an edge register
  for (genvar e = 0; e < NUM_EDGES; e++) begin : g_edge
    // (RULE_08) Edges reset to disabled
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        skip_band_edges[e] <= SKIP_RST;
      end else if (clk_en && ok_skip && (addr == 4'(OFF_SKIP_BASE + e))) begin
        skip_band_edges[e] <= wr_data;
      end
    end
  end

  // Sticky refused-write flag; a new refusal wins over a clear
  // Read-only and unmapped offsets drop writes without raising it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      write_rejected <= 1'b0;
    end else if (clk_en) begin
      if (mapped_setting && !accepted) begin
        write_rejected <= 1'b1;
      end else if (sel_status && wr_data[ST_REJECT]) begin
        write_rejected <= 1'b0;
      end
    end
  end

  // Command source: jog setting replaces the command during jog
  // The external command is ignored entirely while jogging
  assign source_freq = jog ? jog_freq_setting : freq_cmd;

  // One detector per band
  // Bands are matched in parallel; priority is settled below
  for (genvar b = 0; b < NUM_BANDS; b++) begin : g_band
    skip_band u_band (
      .freq_in    (source_freq),
      .edge_a     (skip_band_edges[2 * b]),
      .edge_b     (skip_band_edges[2 * b + 1]),
      .hit        (band_hit[b]),
      .jump_point (band_point[b])
    );
  end

  // First matching band wins; overlapping bands resolve by band number
  // Walking from the top band down leaves the lowest band's point
  always_comb begin
    skipped_freq = source_freq;
    any_hit      = 1'b0;
    for (int b = NUM_BANDS - 1; b >= 0; b--) begin
      if (band_hit[b]) begin
        // (RULE_09) Hold at A edge
        // (RULE_10) A low or high edge
        skipped_freq = band_point[b];
        any_hit      = 1'b1;
      end
    end
  end

  // (RULE_13) Clamp after skip mapping
  freq_clamp u_target_clamp (
    .freq_in     (skipped_freq),
    .lower_limit (lower_freq_limit),
    .upper_limit (max_freq),
    .jog_mode    (jog),
    .freq_out    (limited_target),
    .at_upper    (tgt_upper),
    .at_lower    (tgt_lower),
    .jog_prec    (tgt_jog_prec)
  );

  // (RULE_11) Ramp frequency is only clamped, never skipped
  freq_clamp u_running_clamp (
    .freq_in     (ramp_freq),
    .lower_limit (lower_freq_limit),
    .upper_limit (max_freq),
    .jog_mode    (jog),
    .freq_out    (limited_running),
    .at_upper    (),
    .at_lower    (),
    .jog_prec    (run_jog_prec)
  );

  // Start with no command present
  // A bare start with the lower limit at or below the starting setting must not run the drive
  assign start_only = start && !jog && (freq_cmd == FREQ_ZERO);

  // Steady target selection
  always_comb begin
    if (!start && !jog) begin
      next_target = FREQ_ZERO;
    end else if (start_only && (lower_freq_limit <= starting_freq_setting)) begin
      next_target = FREQ_ZERO;
    end else begin
      // (RULE_06) Start alone runs to lower limit
      // (RULE_04) Lower clamp
      // (RULE_05) Jog precedence
      // (RULE_01) Upper clamp
      // (RULE_02) Ceiling as upper limit
      next_target = limited_target;
    end
  end

  // Registered steady target and its flags
  // Flags are qualified by run so a stopped drive reports nothing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      target_freq   <= FREQ_ZERO;
      upper_clamped <= 1'b0;
      lower_clamped <= 1'b0;
      skip_engaged  <= 1'b0;
    end else if (clk_en) begin
      target_freq   <= next_target;
      upper_clamped <= (start || jog) && tgt_upper;
      lower_clamped <= (start || jog) && tgt_lower;
      // (RULE_11) Skip only reported for the steady target
      skip_engaged  <= (start || jog) && any_hit && !ramp_active;
    end
  end

  // Registered running frequency toward the modulator
  // Only clamped, so the ramp still crosses the bands it must
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      running_freq <= FREQ_ZERO;
    end else if (clk_en) begin
      running_freq <= (start || jog || ramp_active) ? limited_running : FREQ_ZERO;
    end
  end

  // Jog precedence indicator
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      jog_prec_seen <= 1'b0;
    end else if (clk_en) begin
      jog_prec_seen <= tgt_jog_prec || run_jog_prec;
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_rd_data = FREQ_ZERO;
    case (addr)
      OFF_UPPER:   next_rd_data = max_freq;
      OFF_CEILING: next_rd_data = max_freq;
      OFF_LOWER:   next_rd_data = lower_freq_limit;
      OFF_JOG:     next_rd_data = jog_freq_setting;
      OFF_START:   next_rd_data = starting_freq_setting;
      OFF_UGRS:    next_rd_data = user_group_read_select;
      OFF_STATUS: begin
        next_rd_data[ST_UPPER]    = upper_clamped;
        next_rd_data[ST_LOWER]    = lower_clamped;
        next_rd_data[ST_SKIP]     = skip_engaged;
        next_rd_data[ST_REJECT]   = write_rejected;
        next_rd_data[ST_JOG_PREC] = jog_prec_seen;
      end
      OFF_TARGET:  next_rd_data = target_freq;
      OFF_RUNNING: next_rd_data = running_freq;
      default: begin
        // Edge offsets fall through here; the rest read zero
        if (in_skip_range) begin
          next_rd_data = skip_band_edges[3'(skip_index)];
        end
      end
    endcase
  end

  // Read data stands in the enabled cycle after the strobe; clk_en low holds it longer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= FREQ_ZERO;
    end else if (clk_en) begin
      rd_data <= rd_en ? next_rd_data : FREQ_ZERO;
    end
  end

endmodule // output_frequency_limiter

// ===== verification/limiter_sva.sv
// Port assertions for the output frequency limiter
`timescale 1ns/1ps
module limiter_chk
  import freq_limit_pkg::*;
(
  input wire logic  clock,
  input wire logic  reset_n,
  input wire logic  clk_en,
  input wire logic  wr_en,
  input wire logic  rd_en,
  input wire logic  start,
  input wire logic  jog,
  input wire logic  ramp_active,
  input wire freq_t freq_cmd,
  input wire freq_t rd_data,
  input wire freq_t target_freq,
  input wire freq_t running_freq,
  input wire logic  upper_clamped,
  input wire logic  lower_clamped,
  input wire logic  skip_engaged
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Read port and outputs at rest
  a_rd_idle_zero: assert property (clk_en && !rd_en |=> rd_data == 16'h0)
    else $error("read data not cleared");
  a_target_idle: assert property (clk_en && !start && !jog |=> target_freq == 16'h0)
    else $error("target not zero while stopped");
  a_running_idle: assert property (clk_en && !start && !jog && !ramp_active
    |=> running_freq == 16'h0) else $error("running not zero while stopped");
  // Clamp and skip flags
  a_skip_ramp: assert property (clk_en && ramp_active |=> !skip_engaged)
    else $error("skip flag during ramp");
  a_clamp_excl: assert property (!(upper_clamped && lower_clamped))
    else $error("both clamp flags set");
  a_lower_range: assert property (lower_clamped |-> target_freq <= FREQ_120HZ)
    else $error("lower clamp above range");
  a_jog_no_raise: assert property (clk_en && jog |=> !lower_clamped)
    else $error("jog raised to lower limit");
  // Target holds while its causes hold
  a_target_steady: assert property ($past(reset_n) && clk_en && $past(clk_en) && !wr_en
    && !$past(wr_en) && $stable(freq_cmd) && $stable(start) && $stable(jog)
    |=> $stable(target_freq)) else $error("target moved with steady inputs");
  // Clock enable low freezes target, running, read data and skip flag
  a_freeze_hold: assert property (!clk_en |=> $stable(target_freq) && $stable(running_freq)
    && $stable(rd_data) && $stable(skip_engaged))
    else $error("outputs moved with clock enable low");
endmodule // limiter_chk

bind output_frequency_limiter limiter_chk limiter_chk_i (.clock(clock), .reset_n(reset_n),
  .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en), .start(start), .jog(jog),
  .ramp_active(ramp_active), .freq_cmd(freq_cmd), .rd_data(rd_data),
  .target_freq(target_freq), .running_freq(running_freq), .upper_clamped(upper_clamped),
  .lower_clamped(lower_clamped), .skip_engaged(skip_engaged));

// ===== verification/freq_source_model.sv
// Command source and ramp stage model facing the limiter
`timescale 1ns/1ps
module freq_source_model
  import freq_limit_pkg::*;
#(
  parameter freq_t STEP = 16'h0014
) (
  input  wire logic  clock,
  input  wire logic  reset_n,
  input  wire logic  analog,
  input  wire freq_t gain_freq,
  input  wire freq_t cmd_req,
  input  wire freq_t target_freq,
  output freq_t      freq_cmd,
  output logic       ramp_active,
  output freq_t      ramp_freq
);
  assign freq_cmd = (analog && cmd_req > gain_freq) ? gain_freq : cmd_req;
  // Ramp runs while the running value trails the target
  assign ramp_active = (ramp_freq != target_freq);
  // Fixed step per cycle, passing through any band on the way
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ramp_freq <= FREQ_ZERO;
    end else if (ramp_freq + STEP < target_freq) begin
      ramp_freq <= ramp_freq + STEP;
    end else if (ramp_freq > target_freq + STEP) begin
      ramp_freq <= ramp_freq - STEP;
    end else begin
      ramp_freq <= target_freq;
    end
  end
endmodule // freq_source_model

// ===== verification/output_frequency_limiter_test.sv
// Self-checking bench for the output frequency limiter
`timescale 1ns/1ps
module output_frequency_limiter_test;
  import freq_limit_pkg::*;
  logic  clock, reset_n, clk_en, wr_en, rd_en, start, jog, analog, ramp_active;
  logic  upper_clamped, lower_clamped, skip_engaged, hit, in_band;
  addr_t addr;
  freq_t wr_data, rd_data, cmd_req, freq_cmd, ramp_freq, target_freq, running_freq;
  freq_t up, lo, jogs, sts, lfsr;
  freq_t edg [6];
  freq_t corner [10] = '{16'h012c, 16'h0190, 16'h015e, 16'h0258, 16'h02bc, 16'h028a,
                         16'h0063, 16'h0064, 16'h03e8, 16'h03e9};
  int    failures, samples_checked;

  output_frequency_limiter output_frequency_limiter_i (.clock(clock), .reset_n(reset_n),
    .clk_en(clk_en), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .freq_cmd(freq_cmd), .start(start), .jog(jog),
    .ramp_active(ramp_active), .ramp_freq(ramp_freq), .target_freq(target_freq),
    .running_freq(running_freq), .upper_clamped(upper_clamped),
    .lower_clamped(lower_clamped), .skip_engaged(skip_engaged));
  freq_source_model freq_source_model_i (.clock(clock), .reset_n(reset_n), .analog(analog),
    .gain_freq(FREQ_50HZ), .cmd_req(cmd_req), .target_freq(target_freq),
    .freq_cmd(freq_cmd), .ramp_active(ramp_active), .ramp_freq(ramp_freq));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compare and count
  task automatic check(string what, freq_t seen, freq_t exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts, verdict and stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(addr_t a, freq_t d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask

  // Read, mask and compare the word of the next cycle
  task automatic rd_chk(addr_t a, freq_t m, freq_t e);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 check("rd_data", rd_data & m, e);
  endtask

  // Sixteen-bit shift register for random commands
  function automatic freq_t next_rand(freq_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Band mapping; the lowest numbered band wins
  function automatic freq_t skip_map(freq_t src);
    freq_t a, b;
    skip_map = src;
    hit = 1'b0;
    for (int i = 4; i >= 0; i -= 2) begin
      a = edg[i];
      b = edg[i+1];
      if (a != SKIP_DISABLED && b != SKIP_DISABLED &&
          src >= (a < b ? a : b) && src <= (a < b ? b : a)) begin
        skip_map = a;
        hit = 1'b1;
      end
    end
  endfunction

  // Wait for the ramp to settle, noting any visit inside the first band
  task automatic settle();
    int k;
    for (k = 0; k < 300 && ramp_active !== 1'b0; k++) begin
      @(posedge clock);
      #1 in_band |= (running_freq > 16'h012c && running_freq < 16'h0190);
    end
    if (k == 300) begin
      failures++;
      $display("[ERR] ramp_active expected 0 seen 1");
      complete_run();
    end else begin
      repeat (2) @(posedge clock);
      #1;
    end
  endtask

  // Limit clamp with jog precedence at or below the lower limit
  function automatic freq_t clamp_f(freq_t f, logic jg);
    if (f > up) return up;
    if (f >= lo || (jg && f <= lo)) return f;
    return lo;
  endfunction

  // Drive one command and check target, flags and the settled ramp
  task automatic apply(freq_t cmd, logic st, logic jg);
    freq_t c, s, e;
    @(posedge clock);
    cmd_req <= cmd;
    start   <= st;
    jog     <= jg;
    c = (analog && cmd > FREQ_50HZ) ? FREQ_50HZ : cmd;
    s = skip_map(jg ? jogs : c);
    e = clamp_f(s, jg);
    if (!jg && c == FREQ_ZERO) e = (lo > sts) ? lo : FREQ_ZERO;
    if (!st && !jg) e = FREQ_ZERO;
    @(posedge clock);
    #1 check("target_freq", target_freq, e);
    if (c != FREQ_ZERO || jg) begin
      check("upper_clamped", {15'h0, upper_clamped}, {15'h0, (st || jg) && s > up});
      check("lower_clamped", {15'h0, lower_clamped}, {15'h0, st && !jg && s < lo});
    end
    settle();
    check("running_freq", running_freq, (st || jg) ? clamp_f(e, jg) : FREQ_ZERO);
    check("skip_engaged", {15'h0, skip_engaged}, {15'h0, (st || jg) && hit});
  endtask

  // Main sequence
  initial begin
    {reset_n, clk_en, wr_en, rd_en, start, jog, analog, in_band} = 8'h40;
    addr    = 4'h0;
    wr_data = 16'h0;
    cmd_req = 16'h0;
    failures = 0;
    samples_checked = 0;
    lfsr = 16'h8530;
    {up, lo, jogs, sts} = {MAX_FREQ_RST, LOWER_RST, JOG_RST, START_RST};
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(OFF_UPPER, 16'hffff, 16'h04b0);
    rd_chk(OFF_LOWER, 16'hffff, 16'h0000);
    for (int i = 0; i < 6; i++) rd_chk(OFF_SKIP_BASE + addr_t'(i), 16'hffff, 16'h270f);
    $display("test reset values done");
    wr(OFF_CEILING, 16'h0bb8);
    rd_chk(OFF_UPPER, 16'hffff, 16'h0bb8);
    wr(OFF_UPPER, 16'h0320);
    rd_chk(OFF_CEILING, 16'hffff, 16'h0320);
    wr(OFF_UPPER, 16'h04b1);
    wr(OFF_CEILING, 16'h04af);
    rd_chk(OFF_CEILING, 16'hffff, 16'h0320);
    rd_chk(OFF_STATUS, 16'h0008, 16'h0008);
    wr(OFF_STATUS, 16'h0008);
    wr(4'hf, 16'h0001);
    rd_chk(OFF_STATUS, 16'h0008, 16'h0000);
    wr(OFF_SKIP_BASE, 16'h0fa1);
    wr(OFF_UGRS, 16'h0001);
    wr(OFF_SKIP_BASE, 16'h0064);
    wr(OFF_CEILING, 16'h07d0);
    wr(OFF_UGRS, 16'h0000);
    rd_chk(OFF_SKIP_BASE, 16'hffff, 16'h270f);
    rd_chk(OFF_CEILING, 16'hffff, 16'h0320);
    $display("test settings done");
    up = 16'h03e8;
    lo = 16'h0064;
    edg = '{16'h012c, 16'h0190, 16'h02bc, 16'h0258, 16'h03e8, 16'h270f};
    wr(OFF_UPPER, up);
    wr(OFF_LOWER, lo);
    for (int i = 0; i < 6; i++) wr(OFF_SKIP_BASE + addr_t'(i), edg[i]);
    foreach (corner[i]) apply(corner[i], 1'b1, 1'b0);
    repeat (40) begin
      lfsr = next_rand(lfsr);
      apply(16'h0001 + lfsr % 16'h0514, 1'b1, 1'b0);
    end
    $display("test bands and clamps done");
    apply(16'h0064, 1'b1, 1'b0);
    in_band = 1'b0;
    apply(16'h0320, 1'b1, 1'b0);
    check("in_band", {15'h0, in_band}, 16'h0001);
    apply(16'h0320, 1'b0, 1'b1);
    rd_chk(OFF_STATUS, 16'h0017, 16'h0010);
    rd_chk(OFF_TARGET, 16'hffff, jogs);
    rd_chk(OFF_RUNNING, 16'hffff, jogs);
    // Clock enable low freezes the target while the inputs move
    @(posedge clock);
    clk_en <= 1'b0;
    jog    <= 1'b0;
    start  <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check("frozen target", target_freq, jogs);
    @(posedge clock);
    clk_en <= 1'b1;
    analog <= 1'b1;
    apply(16'h0320, 1'b1, 1'b0);
    analog <= 1'b0;
    apply(16'h0000, 1'b1, 1'b0);
    sts = 16'h00c8;
    wr(OFF_START, sts);
    apply(16'h0000, 1'b1, 1'b0);
    apply(16'h0320, 1'b0, 1'b0);
    wr(OFF_CEILING, 16'h0bb8);
    up = 16'h0bb8;
    apply(16'h0fa0, 1'b1, 1'b0);
    apply(16'h0960, 1'b1, 1'b0);
    $display("test jog and start done");
    complete_run();
  end
endmodule // output_frequency_limiter_test
